// >>> logic/dpwm_pkg.sv
// Constants and types of the dual output PWM timer
package dpwm_pkg;
  localparam int          ADDR_W          = 6;
  localparam logic [5:0]  OFS_CTL_FIRST   = 6'h00;
  localparam logic [5:0]  OFS_CTL_SECOND  = 6'h04;
  localparam logic [5:0]  OFS_COUNT       = 6'h08;
  localparam logic [5:0]  OFS_PWM         = 6'h0c;
  localparam logic [5:0]  OFS_RELOAD      = 6'h10;
  localparam logic [5:0]  OFS_DEADBAND    = 6'h14;
  localparam logic [5:0]  OFS_IRQ_STATUS  = 6'h18;
  localparam logic [5:0]  OFS_IRQ_CLEAR   = 6'h1c;
  localparam logic [5:0]  OFS_IRQ_ENABLE  = 6'h20;
  // Field positions
  localparam int          MODEHI_BIT      = 0;
  localparam int          ENABLE_BIT      = 7;
  localparam int          POL_BIT         = 6;
  localparam int          PSC_LSB         = 3;
  localparam int          MODE_LSB        = 0;
  localparam int          WRAP_BIT        = 0;
  // Reset values
  localparam logic [7:0]  CTL_RST         = 8'h00;
  localparam logic [15:0] COUNT_RST       = 16'h0001;
  localparam logic [15:0] PWM_RST         = 16'h0000;
  localparam logic [15:0] RELOAD_RST      = 16'hffff;
  localparam logic [7:0]  DEADBAND_RST    = 8'h00;
  localparam logic [0:0]  IRQ_RST         = 1'h0;
  // Mode, counting and response constants
  localparam logic [3:0]  MODE_DUAL_PWM   = 4'h8;
  localparam logic [15:0] COUNT_RESTART   = 16'h0001;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DEAD = 2'b10
  } dpwm_state_type;

  typedef struct packed {
    logic comp_sel;
    logic comp_out;
    logic pwm_out;
  } dpwm_pins_type;
endpackage : dpwm_pkg

// >>> logic/dpwm_timer.sv
// Dual output PWM timer with dead band and AXI4-Lite registers
// Overview of operation
// - While the timer runs in dual PWM mode with a nonzero dead band, a dead band follows each fall of one output before the other output may rise.
// - After every counter reset the count restarts from 0001H, start value only once.
// - Dual PWM mode hands the shared pin from timer input to complement output.
// - The period is reload value times prescale, in system clocks.
// - A start count other than 0001H makes the first period run from it to reload.
// - With polarity 0 and no dead band the output is high for reload minus PWM counts of each period.
// - With polarity 1 and no dead band the output is high for PWM counts of each period.
`timescale 1ns/1ps
module dpwm_timer
  import dpwm_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0]     awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0]     araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Timer pins and interrupt
  output dpwm_pkg::dpwm_pins_type    pins,
  output logic                       irq
);
  import dpwm_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = val[8*i +: 8];
    end
    return res;
  endfunction : merge

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == OFS_CTL_FIRST || a == OFS_CTL_SECOND || a == OFS_COUNT ||
           a == OFS_PWM || a == OFS_RELOAD || a == OFS_DEADBAND ||
           a == OFS_IRQ_STATUS || a == OFS_IRQ_CLEAR || a == OFS_IRQ_ENABLE;
  endfunction : is_mapped

  logic                awready_reg;
  logic                wready_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                arready_reg;
  logic                rvalid_reg;
  logic [1:0]          rresp_reg;
  logic [31:0]         rdata_reg;
  logic [ADDR_W-1:0]   waddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic [7:0]          ctl_first_reg;
  logic [7:0]          ctl_second_reg;
  logic [15:0]         count_reg;
  logic [15:0]         pwm_reg;
  logic [15:0]         reload_reg;
  logic [7:0]          deadband_reg;
  logic [0:0]          irq_status_reg;
  logic [0:0]          irq_enable_reg;
  logic                irq_reg;
  logic [7:0]          psc_cnt_reg;
  logic [7:0]          db_cnt_reg;
  logic                raw_prev_reg;
  dpwm_state_type      st_reg;
  dpwm_state_type      st_next;
  dpwm_pins_type       pins_reg;
  dpwm_pins_type       pins_next;

  // Bus decode
  wire                 wr_fire   = !awready_reg && !wready_reg && !bvalid_reg;
  wire                 wr_ok     = wr_fire && is_mapped(waddr_reg);
  wire [31:0]          wr_val    = merge(32'h0, wdata_reg, wstrb_reg);
  wire                 wr_first  = wr_ok && waddr_reg == OFS_CTL_FIRST;
  wire                 wr_second = wr_ok && waddr_reg == OFS_CTL_SECOND;
  wire                 wr_count  = wr_ok && waddr_reg == OFS_COUNT;
  wire                 wr_pwm    = wr_ok && waddr_reg == OFS_PWM;
  wire                 wr_reload = wr_ok && waddr_reg == OFS_RELOAD;
  wire                 wr_db     = wr_ok && waddr_reg == OFS_DEADBAND;
  wire                 wr_clear  = wr_ok && waddr_reg == OFS_IRQ_CLEAR;
  wire                 wr_ien    = wr_ok && waddr_reg == OFS_IRQ_ENABLE;
  wire                 rd_take   = arvalid && arready_reg;
  wire [31:0]          rd_val    =
    araddr == OFS_CTL_FIRST  ? {24'h0, ctl_first_reg} :
    araddr == OFS_CTL_SECOND ? {24'h0, ctl_second_reg} :
    araddr == OFS_COUNT      ? {16'h0, count_reg} :
    araddr == OFS_PWM        ? {16'h0, pwm_reg} :
    araddr == OFS_RELOAD     ? {16'h0, reload_reg} :
    araddr == OFS_DEADBAND   ? {24'h0, deadband_reg} :
    araddr == OFS_IRQ_STATUS ? {31'h0, irq_status_reg} :
    araddr == OFS_IRQ_ENABLE ? {31'h0, irq_enable_reg} : 32'h0;

  // Timer decode
  wire                 enabled   = ctl_second_reg[ENABLE_BIT];
  wire                 pol       = ctl_second_reg[POL_BIT];
  wire [2:0]           psc_sel   = ctl_second_reg[PSC_LSB +: 3];
  wire [7:0]           psc_div   = 8'h01 << psc_sel;
  wire [3:0]           mode      = {ctl_first_reg[MODEHI_BIT], ctl_second_reg[MODE_LSB +: 3]};
  wire                 dual      = mode == MODE_DUAL_PWM;
  wire                 tick      = enabled && psc_cnt_reg == psc_div - 8'h01;
  wire                 at_reload = count_reg == reload_reg;
  wire                 wrap      = tick && at_reload;
  wire                 raw       = pol ? count_reg <= pwm_reg : count_reg > pwm_reg;
  wire                 edge_seen = raw != raw_prev_reg;
  wire                 db_done   = tick && db_cnt_reg <= 8'h01;
  wire [0:0]           irq_set   = wrap ? 1'h1 : 1'h0;
  wire [0:0]           status_nx = irq_set | (irq_status_reg & ~(wr_clear ? wr_val[0:0] : 1'h0));

  // Write channels: address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else if (bvalid_reg && bready)
    begin
      bvalid_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
    end
    else
    begin
      if (awvalid && awready_reg)
        awready_reg <= 1'b0;
      if (wvalid && wready_reg)
        wready_reg <= 1'b0;
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      waddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (awvalid && awready_reg)
        waddr_reg <= awaddr;
      if (wvalid && wready_reg)
      begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
    end
  end

  // Read channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0;
    end
    else if (rd_take)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_val;
      rresp_reg   <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && rready)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_first_reg  <= CTL_RST;
      ctl_second_reg <= CTL_RST;
      pwm_reg        <= PWM_RST;
      reload_reg     <= RELOAD_RST;
      deadband_reg   <= DEADBAND_RST;
      irq_enable_reg <= IRQ_RST;
    end
    else
    begin
      if (wr_first)
        ctl_first_reg <= wr_val[7:0];
      if (wr_second)
        ctl_second_reg <= wr_val[7:0];
      if (wr_pwm)
        pwm_reg <= wr_val[15:0];
      if (wr_reload)
        reload_reg <= wr_val[15:0];
      if (wr_db)
        deadband_reg <= wr_val[7:0];
      if (wr_ien)
        irq_enable_reg <= wr_val[0:0];
    end
  end

  // Prescaler and counter; a written start count runs only the first pass
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      psc_cnt_reg <= 8'h00;
      count_reg   <= COUNT_RST;
    end
    else
    begin
      psc_cnt_reg <= (!enabled || tick) ? 8'h00 : psc_cnt_reg + 8'h01;
      if (wr_count)
        count_reg <= wr_val[15:0];
      else if (wrap)
        count_reg <= COUNT_RESTART;
      else if (tick)
        count_reg <= count_reg + 16'h0001;
    end
  end

  // Sticky event status, set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status_reg <= IRQ_RST;
      irq_reg        <= 1'b0;
    end
    else
    begin
      irq_status_reg <= status_nx;
      irq_reg        <= |(status_nx & (wr_ien ? wr_val[0:0] : irq_enable_reg));
    end
  end

  // Dead band sequencer
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE:
        if (enabled)
          st_next = ST_RUN;
      ST_RUN:
        if (!enabled)
          st_next = ST_IDLE;
        else if (dual && edge_seen && deadband_reg != 8'h00)
          st_next = ST_DEAD;
      ST_DEAD:
        if (!enabled)
          st_next = ST_IDLE;
        else if (db_done)
          st_next = ST_RUN;
      default:
        st_next = ST_IDLE;
    endcase
  end

  always_comb
  begin
    pins_next.comp_sel = dual;
    if (st_next == ST_IDLE)
    begin
      pins_next.pwm_out  = pol;
      pins_next.comp_out = dual && !pol;
    end
    else
    begin
      pins_next.pwm_out  = st_next == ST_RUN && raw;
      pins_next.comp_out = dual && st_next == ST_RUN && !raw;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg       <= ST_IDLE;
      db_cnt_reg   <= 8'h00;
      raw_prev_reg <= 1'b0;
      pins_reg     <= '0;
    end
    else
    begin
      st_reg       <= st_next;
      raw_prev_reg <= raw;
      pins_reg     <= pins_next;
      if (st_reg == ST_RUN && st_next == ST_DEAD)
        db_cnt_reg <= deadband_reg;
      else if (st_reg == ST_DEAD && tick)
        db_cnt_reg <= db_cnt_reg - 8'h01;
    end
  end

  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;
  assign pins    = pins_reg;
  assign irq     = irq_reg;

  // Checks
  logic [31:0]         gap_reg;
  logic                seen_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enabled)
    begin
      gap_reg  <= 32'h0;
      seen_reg <= 1'b0;
    end
    else
    begin
      gap_reg  <= wrap ? 32'h0 : gap_reg + 32'h1;
      seen_reg <= seen_reg || wrap;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_enter_dead;
    st_reg == ST_RUN && st_next == ST_DEAD;
  endsequence
  property p_no_overlap;
    !(pins.pwm_out && pins.comp_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both outputs high");
  property p_dead_low;
    s_enter_dead |=> !pins.pwm_out && !pins.comp_out;
  endproperty
  a_dead_low: assert property (p_dead_low) else $error("outputs not low in dead band");
  property p_restart;
    wrap && !wr_count |=> count_reg == COUNT_RESTART;
  endproperty
  a_restart: assert property (p_restart) else $error("counter did not restart at 1");
  property p_pin_swap;
    dual |=> pins.comp_sel;
  endproperty
  a_pin_swap: assert property (p_pin_swap) else $error("shared pin not switched");
  property p_period;
    wrap && seen_reg && $stable(ctl_second_reg) && $stable(reload_reg) |->
      gap_reg == 32'(reload_reg) * 32'(psc_div) - 32'h1;
  endproperty
  a_period: assert property (p_period) else $error("period not reload times prescale");
  property p_first_pass;
    $rose(enabled) && !wr_count |=> count_reg == $past(count_reg) || $past(tick);
  endproperty
  a_first_pass: assert property (p_first_pass) else $error("start count lost");
  property p_pol_low;
    !pol && count_reg > pwm_reg && st_next == ST_RUN |=> pins.pwm_out;
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("output low in high phase");
  property p_pol_high;
    pol && count_reg <= pwm_reg && st_next == ST_RUN |=> pins.pwm_out;
  endproperty
  a_pol_high: assert property (p_pol_high) else $error("output low in high phase");
  property p_step;
    tick && !at_reload && !wr_count |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");
  property p_irq;
    wrap && irq_enable_reg && !wr_ien |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt at reload");
  property p_complement;
    dual && st_next == ST_RUN |=> pins.comp_out != pins.pwm_out;
  endproperty
  a_complement: assert property (p_complement) else $error("complement not inverse");
endmodule : dpwm_timer

// >>> verif/dpwm_load.sv
// Load model: a switch pair driven by the complementary outputs
`timescale 1ns/1ps
module dpwm_load
  import dpwm_pkg::*;
(
  // Clock and counter clear
  input  wire logic                    aclk,
  input  wire logic                    clr,
  // Pins from the timer
  input  wire dpwm_pkg::dpwm_pins_type pins,
  // Conduction counts in clock cycles
  output logic [15:0]                  hi_pwm,
  output logic [15:0]                  hi_comp,
  output logic [15:0]                  both_on
);
  always_ff @(posedge aclk)
  begin
    if (clr)
    begin
      hi_pwm  <= 16'h0000;
      hi_comp <= 16'h0000;
      both_on <= 16'h0000;
    end
    else
    begin
      hi_pwm  <= hi_pwm + {15'h0000, pins.pwm_out};
      hi_comp <= hi_comp + {15'h0000, pins.comp_out};
      // Both switches closed would short the supply
      both_on <= both_on + {15'h0000, pins.pwm_out & pins.comp_out};
    end
  end
endmodule : dpwm_load

// >>> verif/testbench.sv
// Register level testbench of the dual output PWM timer
`timescale 1ns/1ps
module testbench;
  import dpwm_pkg::*;
  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, irq, clr;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rs;
  logic [15:0]       hi_pwm, hi_comp, both_on;
  dpwm_pins_type     pins;
  int                mismatches, cmp_count, cyc, t0, t1, t2;
  logic [5:0]        ra [4] = '{OFS_COUNT, OFS_PWM, OFS_RELOAD, OFS_DEADBAND};
  logic [31:0]       rv [4] = '{32'h0001, 32'h0000, 32'hffff, 32'h0000};

  dpwm_timer dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pins(pins), .irq(irq));
  dpwm_load load (.aclk(aclk), .clr(clr), .pins(pins), .hi_pwm(hi_pwm), .hi_comp(hi_comp),
    .both_on(both_on));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) cyc <= cyc + 1;

  task final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask : cycles

  task axi_write(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done, b_done;
    int   n;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_done = 1'b0;
    w_done  = 1'b0;
    b_done  = 1'b0;
    n       = 0;
    while (!b_done && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (aw_done && w_done && bvalid === 1'b1)
      begin
        b_done = 1'b1;
        // Bready stays high so back to back writes never drive it twice in one step
        check("bresp", {30'h0, bresp}, {30'h0, er});
      end
    end
    if (!b_done)
    begin
      mismatches++;
      final_report;
    end
  endtask : axi_write

  task axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    int   n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    done    = 1'b0;
    n       = 0;
    while (!done && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        done = 1'b1;
        d    = rdata;
        r    = rresp;
      end
    end
    if (!done)
    begin
      mismatches++;
      final_report;
    end
  endtask : axi_read

  function automatic logic [31:0] ctl2(input logic en, input logic pol, input logic [2:0] psc);
    ctl2                  = 32'h0;
    ctl2[ENABLE_BIT]      = en;
    ctl2[POL_BIT]         = pol;
    ctl2[PSC_LSB +: 3]    = psc;
    ctl2[MODE_LSB +: 3]   = MODE_DUAL_PWM[2:0];
  endfunction : ctl2

  // Reload 8, compare 2: measure four whole periods after settling
  task run_pwm(input logic pol, input logic [2:0] psc, input int db);
    int per, hp, hc;
    per = 8 << psc;
    hp  = (pol ? 2 - db : 6 - db) << psc;
    hc  = (pol ? 6 - db : 2 - db) << psc;
    axi_write(OFS_CTL_SECOND, ctl2(1'b0, pol, psc), RESP_OKAY);
    cycles(2);
    check("idle pins", {29'h0, pins}, {29'h0, 1'b1, ~pol, pol});
    axi_write(OFS_COUNT, 32'h1, RESP_OKAY);
    axi_write(OFS_PWM, 32'h2, RESP_OKAY);
    axi_write(OFS_DEADBAND, 32'(db), RESP_OKAY);
    axi_write(OFS_RELOAD, 32'h8, RESP_OKAY);
    axi_write(OFS_CTL_SECOND, ctl2(1'b1, pol, psc), RESP_OKAY);
    cycles(2 * per);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    cycles(4 * per + 1);
    check("pwm high", {16'h0, hi_pwm}, 32'(4 * hp));
    check("comp high", {16'h0, hi_comp}, 32'(4 * hc));
    check("overlap", {16'h0, both_on}, 32'h0);
  endtask : run_pwm

  task wait_irq(output int t);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    if (irq === 1'b1)
      t = cyc;
    else
    begin
      mismatches++;
      final_report;
    end
  endtask : wait_irq

  initial
  begin
    repeat (100000) @(posedge aclk);
    mismatches++;
    final_report;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr     = 6'h00;
    araddr     = 6'h00;
    wdata      = 32'h0;
    wstrb      = 4'hf;
    clr        = 1'b1;
    cyc        = 0;
    mismatches = 0;
    cmp_count  = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    cycles(2);
    check("reset pins", {29'h0, pins}, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      axi_read(ra[i], rd, rs);
      check("reset value", rd, rv[i]);
    end
    axi_read(6'h24, rd, rs);
    check("unmapped rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    check("unmapped rdata", rd, 32'h0);
    axi_write(6'h24, 32'h1, RESP_SLVERR);
    axi_write(OFS_CTL_FIRST, 32'h1 << MODEHI_BIT, RESP_OKAY);
    run_pwm(1'b0, 3'h0, 1);
    run_pwm(1'b1, 3'h0, 1);
    run_pwm(1'b0, 3'h1, 0);
    // Masked event still latches status
    axi_write(OFS_CTL_SECOND, ctl2(1'b0, 1'b0, 3'h2), RESP_OKAY);
    axi_write(OFS_IRQ_CLEAR, 32'h1, RESP_OKAY);
    axi_write(OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
    axi_write(OFS_CTL_SECOND, ctl2(1'b1, 1'b0, 3'h2), RESP_OKAY);
    cycles(40);
    check("masked irq", {31'h0, irq}, 32'h0);
    axi_read(OFS_IRQ_STATUS, rd, rs);
    check("status set", rd, 32'h1);
    axi_write(OFS_CTL_SECOND, ctl2(1'b0, 1'b0, 3'h2), RESP_OKAY);
    axi_write(OFS_IRQ_CLEAR, 32'h1, RESP_OKAY);
    axi_read(OFS_IRQ_STATUS, rd, rs);
    check("status clear", rd, 32'h0);
    // Start count 5: first pass four ticks, then full periods from 0001H
    axi_write(OFS_IRQ_ENABLE, 32'h1, RESP_OKAY);
    axi_write(OFS_COUNT, 32'h5, RESP_OKAY);
    axi_write(OFS_CTL_SECOND, ctl2(1'b1, 1'b0, 3'h2), RESP_OKAY);
    t0 = cyc;
    wait_irq(t1);
    check("first pass", 32'(t1 - t0), 32'd16);
    axi_write(OFS_IRQ_CLEAR, 32'h1, RESP_OKAY);
    cycles(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wait_irq(t2);
    check("later pass", 32'(t2 - t1), 32'd32);
    // Leaving dual mode hands the shared pin back to the timer input
    axi_write(OFS_CTL_SECOND, ctl2(1'b0, 1'b0, 3'h0), RESP_OKAY);
    axi_write(OFS_CTL_FIRST, 32'h0, RESP_OKAY);
    cycles(2);
    check("input pin", {29'h0, pins}, 32'h0);
    final_report;
  end
endmodule : testbench
